//--- pmbus_host.sv
`timescale 1ns/1ps
module pmbus_host
  import pmbus_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // serial bus
  pmbus_if.host            bus,
  // command port
  input  wire logic        go,
  input  wire op_t         go_op,
  input  wire logic [6:0]  go_addr,
  input  wire logic [7:0]  go_cmd,
  input  wire logic [15:0] go_data,
  input  wire logic        go_pec,
  // results
  output logic             busy,
  output logic             done,
  output logic             nacked,
  output logic             pec_bad,
  output logic             rx_valid,
  output logic      [7:0]  rx_byte
);

  typedef enum logic [2:0] {h_idle, h_start, h_byte, h_stop, h_pulse} hst_t;

  typedef struct packed {
    hst_t            st;
    op_t             op;
    logic            pec;
    logic [QW-1:0]   tq;
    logic [1:0]      qc;
    logic [3:0]      bn;
    logic            tx;
    logic [7:0]      sh;
    logic [3:0][7:0] wb;
    logic [2:0]      wi;
    logic [2:0]      wlen;
    logic            rdph;
    logic            pecsent;
    logic            first;
    logic [8:0]      rn;
    logic [7:0]      crc;
    logic [4:0]      pcnt;
    logic            ackbit;
    logic [1:0]      sda_sy;
    logic            scl_oe;
    logic            sda_oe;
    logic            busy;
    logic            done;
    logic            nacked;
    logic            pec_bad;
    logic            rx_valid;
    logic [7:0]      rx_byte;
  } host_t;

  host_t s;
  host_t n;

  always_comb begin
    logic       tick;
    logic       is_wr;
    logic [8:0] r;
    logic [2:0] wi1;
    n = s;
    n.sda_sy = {s.sda_sy[0], bus.sda};
    n.done = 1'b0;
    n.rx_valid = 1'b0;
    tick = (s.tq == QW'(QTR_CYC - 1));
    n.tq = tick ? '0 : s.tq + 1'b1;
    is_wr = (s.op == op_send_byte) || (s.op == op_write_byte) || (s.op == op_write_word);
    r = s.rn - 9'h001;
    if (s.first && s.op == op_block_read) begin
      r = {1'b0, s.sh} + {8'h00, s.pec};
    end
    wi1 = s.wi + 3'h1;
    if (s.st == h_idle) begin
      if (go) begin
        n.busy = 1'b1;
        n.op = go_op;
        n.pec = go_pec; // see RULE8
        n.nacked = 1'b0;
        n.pec_bad = 1'b0;
        n.crc = CRC_INIT;
        n.wb[0] = {go_addr, go_op == op_recv_byte};
        n.wb[1] = go_cmd;
        n.wb[2] = go_data[7:0];
        n.wb[3] = go_data[15:8];
        n.wi = 3'h0;
        n.rdph = (go_op == op_recv_byte);
        n.pecsent = 1'b0;
        n.first = 1'b1;
        n.wlen = 3'h2;
        n.rn = {8'h00, go_pec};
        unique case (go_op)
          op_recv_byte:  begin n.wlen = 3'h1; n.rn = 9'h001 + {8'h00, go_pec}; end
          op_write_byte: n.wlen = 3'h3;
          op_write_word: n.wlen = 3'h4;
          op_read_word:  n.rn = 9'h002 + {8'h00, go_pec};
          op_read_byte,
          op_block_read: n.rn = 9'h001 + {8'h00, go_pec};
          default: ;
        endcase
        n.st = (go_op == op_recover) ? h_pulse : h_start;
        n.qc = 2'h0;
        n.pcnt = 5'h00;
        n.tq = '0;
      end
    end else if (tick) begin
      n.qc = s.qc + 2'h1;
      unique case (s.st)
        h_start: begin
          unique case (s.qc)
            2'h0: n.sda_oe = 1'b0;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b1;
            2'h3: begin
              n.scl_oe = 1'b1;
              n.st = h_byte;
              n.bn = 4'h0;
              n.tx = 1'b1;
              n.sh = s.wb[s.wi];
              n.crc = crc8_step(s.crc, s.wb[s.wi]);
            end
          endcase
        end
        h_byte: begin
          unique case (s.qc)
            2'h0: begin
              if (s.bn < 4'h8) begin
                n.sda_oe = s.tx & ~s.sh[7];
              end else if (s.tx) begin
                n.sda_oe = 1'b0;
              end else begin
                n.rn = r;
                n.first = 1'b0;
                n.crc = crc8_step(s.crc, s.sh);
                n.sda_oe = (r != 9'h000); // see RULE11 // see RULE12
                if (s.pec && r == 9'h000) begin
                  n.pec_bad = (crc8_step(s.crc, s.sh) != 8'h00);
                end else begin
                  n.rx_valid = 1'b1;
                  n.rx_byte = s.sh;
                end
              end
            end
            2'h1: n.scl_oe = 1'b0;
            2'h2: begin
              if (s.bn < 4'h8) begin
                n.sh = {s.sh[6:0], s.tx ? 1'b0 : s.sda_sy[1]};
              end else begin
                n.ackbit = s.sda_sy[1];
              end
            end
            2'h3: begin
              n.scl_oe = 1'b1;
              n.bn = s.bn + 4'h1;
              if (s.bn == 4'h8) begin
                n.bn = 4'h0;
                if (s.tx) begin
                  n.wi = wi1;
                  if (s.ackbit) begin
                    n.nacked = 1'b1;
                    n.st = h_stop;
                  end else if (wi1 < s.wlen) begin
                    n.sh = s.wb[wi1];
                    n.crc = crc8_step(s.crc, s.wb[wi1]);
                  end else if (is_wr && s.pec && !s.pecsent) begin
                    n.sh = s.crc; // see RULE4
                    n.pecsent = 1'b1;
                  end else if (is_wr) begin
                    n.st = h_stop;
                  end else if (!s.rdph) begin
                    n.rdph = 1'b1;
                    n.wb[0] = {s.wb[0][7:1], 1'b1};
                    n.wi = 3'h0;
                    n.wlen = 3'h1;
                    n.st = h_start;
                  end else begin
                    n.tx = 1'b0;
                    n.sh = 8'h00;
                  end
                end else if (s.rn == 9'h000) begin
                  n.st = h_stop;
                end
              end
            end
          endcase
        end
        h_stop: begin
          unique case (s.qc)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b0;
            2'h3: begin
              n.st = h_idle;
              n.busy = 1'b0;
              n.done = 1'b1;
            end
          endcase
        end
        h_pulse: begin
          unique case (s.qc)
            2'h0: n.sda_oe = 1'b0;
            2'h1: n.scl_oe = 1'b0;
            2'h2: ;
            2'h3: begin
              n.scl_oe = 1'b1;
              n.pcnt = s.pcnt + 5'h01;
              if (s.pcnt == 5'(RECOVER_PULSES - 1)) begin
                n.st = h_stop; // see RULE10
              end
            end
          endcase
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign bus.host_scl_o  = 1'b0;
  assign bus.host_scl_oe = s.scl_oe;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = s.sda_oe;
  assign busy     = s.busy;
  assign done     = s.done;
  assign nacked   = s.nacked;
  assign pec_bad  = s.pec_bad;
  assign rx_valid = s.rx_valid;
  assign rx_byte  = s.rx_byte;

endmodule // pmbus_host

//--- pmbus_pkg.sv
package pmbus_pkg;
  // clock and serial timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int SCL_PERIOD_NS  = 10000;
  localparam int QTR_CYC        = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int QW             = $clog2(QTR_CYC + 1);
  localparam int RECOVER_PULSES = 16;
  // address bases for the two model variants
  localparam logic [4:0] BASE_MODEL1 = 5'h04;
  localparam logic [4:0] BASE_MODEL2 = 5'h06;
  // address select strap codes, as the strap logic reports them
  localparam logic [1:0] STRAP_NEG_RAIL  = 2'h0;
  localparam logic [1:0] STRAP_NEG_RES   = 2'h1;
  localparam logic [1:0] STRAP_FLOATING  = 2'h2;
  localparam logic [1:0] STRAP_CAP_RAIL  = 2'h3;
  // packet error check and the idle fill byte for reads
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;

  typedef enum logic [2:0] {
    op_send_byte, op_recv_byte, op_write_byte, op_read_byte,
    op_write_word, op_read_word, op_block_read, op_recover
  } op_t;

  function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
endpackage

//--- pmbus_if.sv
`timescale 1ns/1ps
interface pmbus_if;
  logic scl;
  logic sda;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;

  // open-drain wired-and with pull-ups
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

//--- pmbus_target.sv
`timescale 1ns/1ps
// How it works
// RULE1 - fixed five-bit base per model variant
// RULE2 - two low address bits from strap
// RULE3 - serve the seven SMBus message protocols
// RULE4 - target sends PEC on reads; host on writes
// RULE5 - PEC works with every protocol
// RULE6 - PEC optional per message, no setting
// RULE7 - bad write PEC discards command, flags error
// RULE8 - group portion accepted with or without PEC
// RULE9 - start, one pulse, stop locks out acks
// RULE10 - host recovers with 16 pulses or dummy
// RULE11 - host NACKs last read byte only
// RULE12 - receiver ACKs each good byte low
module pmbus_target
  import pmbus_pkg::*;
#(
  parameter bit MODEL2 = 1'b0
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // serial bus
  pmbus_if.dev             bus,
  // address select strap
  input  wire logic [1:0]  adr_strap,
  // command decode from user logic
  output logic      [7:0]  cur_cmd,
  input  wire logic [1:0]  cmd_len,
  input  wire logic [7:0]  rd_len,
  output logic      [7:0]  rd_idx,
  input  wire logic [7:0]  rd_byte,
  // executed writes, PEC error and lock-out flag
  output logic             exec_valid,
  output logic      [7:0]  exec_cmd,
  output logic      [1:0]  exec_len,
  output logic      [15:0] exec_data,
  output logic             pec_err,
  output logic             hung
);

  typedef enum logic [2:0] {st_idle, st_addr, st_wr, st_rd, st_skip} dst_t;

  typedef struct packed {
    dst_t        st;
    logic [2:0]  scl_sy;
    logic [2:0]  sda_sy;
    logic [1:0]  strap_m;
    logic [1:0]  strap_s;
    logic        strap_done;
    logic [1:0]  adr_lo;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        ackp;
    logic        sda_oe;
    logic [1:0]  pulses;
    logic        hung;
    logic [4:0]  hcnt;
    logic        wseg;
    logic        pend;
    logic [2:0]  bc;
    logic [7:0]  cmd;
    logic [7:0]  d0;
    logic [7:0]  d1;
    logic        zc;
    logic [7:0]  crc;
    logic [7:0]  idx;
    logic        exec_valid;
    logic [7:0]  exec_cmd;
    logic [1:0]  exec_len;
    logic [15:0] exec_data;
    logic        pec_err;
  } dev_t;

  dev_t s;
  dev_t n;
  logic [6:0] my_addr;

  assign my_addr = {(MODEL2 ? BASE_MODEL2 : BASE_MODEL1), s.adr_lo}; // see RULE1 // see RULE2

  always_comb begin
    logic       rise;
    logic       fall;
    logic       sta;
    logic       sto;
    logic [7:0] b;
    logic [7:0] tb;
    logic [2:0] nb;
    logic [2:0] ln;
    n = s;
    n.scl_sy = {s.scl_sy[1:0], bus.scl};
    n.sda_sy = {s.sda_sy[1:0], bus.sda};
    n.strap_m = adr_strap;
    n.strap_s = s.strap_m;
    // strap is followed until the first start, then frozen
    if (!s.strap_done) begin
      n.adr_lo = s.strap_s; // see RULE2
    end
    rise = s.scl_sy[1] & ~s.scl_sy[2];
    fall = ~s.scl_sy[1] & s.scl_sy[2];
    sta  = s.scl_sy[1] & s.scl_sy[2] & s.sda_sy[2] & ~s.sda_sy[1];
    sto  = s.scl_sy[1] & s.scl_sy[2] & ~s.sda_sy[2] & s.sda_sy[1];
    b    = {s.sh[6:0], s.sda_sy[1]};
    tb   = IDLE_BYTE;
    nb   = s.bc - 3'h1;
    ln   = {1'b0, cmd_len};
    n.exec_valid = 1'b0;
    n.pec_err = 1'b0;
    if (sta) begin
      n.strap_done = 1'b1;
      // a repeated start parks the write portion until the stop
      n.pend = s.pend | s.wseg; // see RULE8
      if (!s.wseg) begin
        n.crc = CRC_INIT;
      end
      n.wseg = 1'b0;
      n.st = st_addr;
      n.cnt = 4'h0;
      n.sda_oe = 1'b0;
      n.ackp = 1'b0;
      n.pulses = 2'h0;
    end else if (sto) begin
      if (s.pulses == 2'h1 && s.st != st_idle) begin
        n.hung = 1'b1; // see RULE9
        n.hcnt = 5'h00;
      end
      if ((s.wseg | s.pend) && s.bc != 3'h0) begin
        // a trailing extra byte is taken as PEC, so no setting is needed
        if (nb == ln) begin // see RULE6
          n.exec_valid = 1'b1;
        end else if (nb == 3'(ln + 3'h1)) begin
          n.exec_valid = s.zc; // see RULE5
          n.pec_err = ~s.zc; // see RULE7
        end
        n.exec_cmd = s.cmd;
        n.exec_len = cmd_len;
        n.exec_data = {(cmd_len == 2'h2) ? s.d1 : 8'h00, (cmd_len != 2'h0) ? s.d0 : 8'h00};
      end
      n.st = st_idle;
      n.wseg = 1'b0;
      n.pend = 1'b0;
      n.sda_oe = 1'b0;
    end else if (rise) begin
      if (s.pulses != 2'h2) begin
        n.pulses = s.pulses + 2'h1;
      end
      if (s.hung) begin
        n.hcnt = s.hcnt + 5'h01;
        if (s.hcnt == 5'(RECOVER_PULSES - 1)) begin
          n.hung = 1'b0; // see RULE10
        end
      end
      if (s.cnt < 4'h8) begin
        n.sh = (s.st == st_rd) ? {s.sh[6:0], 1'b0} : b;
      end
      n.cnt = s.cnt + 4'h1;
      if (s.cnt == 4'h7) begin
        unique case (s.st)
          st_addr: begin
            n.crc = crc8_step(s.crc, b);
            if (b[7:1] == my_addr && !s.hung) begin
              n.ackp = 1'b1; // see RULE12
              if (b[0]) begin
                n.st = st_rd;
                n.pend = 1'b0;
                n.idx = 8'h00;
              end else begin
                n.st = st_wr;
                n.wseg = 1'b1;
                n.bc = 3'h0;
              end
            end else begin
              n.st = st_skip;
              // traffic to another address releases the lock-out
              if (b[7:1] != my_addr) begin
                n.hung = 1'b0; // see RULE10
              end
            end
          end
          st_wr: begin
            n.crc = crc8_step(s.crc, b);
            n.zc = (crc8_step(s.crc, b) == 8'h00); // see RULE4
            n.ackp = 1'b1; // see RULE12
            unique case (s.bc)
              3'h0: n.cmd = b;
              3'h1: n.d0 = b;
              3'h2: n.d1 = b;
              default: ;
            endcase
            if (s.bc != 3'h7) begin
              n.bc = s.bc + 3'h1;
            end
          end
          default: ;
        endcase
      end
      if (s.cnt == 4'h8 && s.st == st_rd && s.sda_sy[1]) begin
        n.st = st_skip; // see RULE11
      end
    end else if (fall) begin
      if (s.cnt == 4'h8) begin
        n.sda_oe = s.ackp;
        n.ackp = 1'b0;
      end else if (s.cnt == 4'h9) begin
        n.cnt = 4'h0;
        n.sda_oe = 1'b0;
        if (s.st == st_rd) begin
          // data bytes, then PEC, then idle ones for any further reads
          if (s.idx < rd_len) begin // see RULE3
            tb = rd_byte;
            n.crc = crc8_step(s.crc, rd_byte);
          end else if (s.idx == rd_len) begin
            tb = s.crc; // see RULE4
          end
          n.sh = tb;
          n.sda_oe = ~tb[7];
          if (s.idx != 8'hFF) begin
            n.idx = s.idx + 8'h01;
          end
        end
      end else if (s.cnt != 4'h0 && s.st == st_rd) begin
        n.sda_oe = ~s.sh[7];
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = s.sda_oe;
  assign cur_cmd    = s.cmd;
  assign rd_idx     = s.idx;
  assign exec_valid = s.exec_valid;
  assign exec_cmd   = s.exec_cmd;
  assign exec_len   = s.exec_len;
  assign exec_data  = s.exec_data;
  assign pec_err    = s.pec_err;
  assign hung       = s.hung;

endmodule // pmbus_target

//--- pmbus_target_interface_props.sv
`timescale 1ns/1ps
module pmbus_target_interface_props (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  // drivers
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // cycles the target has held sda low without a break
  logic [11:0] hold_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hold_q <= 12'h000;
    end else begin
      hold_q <= dev_sda_oe ? hold_q + 12'h001 : 12'h000;
    end
  end

  property p_open_drain;
    (dev_sda_oe |-> !dev_sda_o) and (host_sda_oe |-> !host_sda_o) and (host_scl_oe |-> !host_scl_o);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high"); // pull low only
  property p_dev_change_low;
    $changed(dev_sda_oe) |-> !scl && !$past(scl);
  endproperty
  a_dev_change_low: assert property (p_dev_change_low) else $error("target sda moved with scl high");
  property p_dev_setup;
    $rose(dev_sda_oe) |=> !scl [*8];
  endproperty
  a_dev_setup: assert property (p_dev_setup) else $error("target data too late"); // ack setup
  property p_start_quiet;
    $fell(sda) && scl && $past(scl) |=> !dev_sda_oe [*8];
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("target drove after start"); // address phase
  property p_stop_release;
    $rose(sda) && scl && $past(scl) |=> (!dev_sda_oe && !host_scl_oe) [*8];
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("bus not idle after stop");
  property p_scl_high_min;
    $rose(scl) |=> scl [*8];
  endproperty
  a_scl_high_min: assert property (p_scl_high_min) else $error("scl high too short");
  property p_scl_low_min;
    $fell(scl) |=> !scl [*8];
  endproperty
  a_scl_low_min: assert property (p_scl_low_min) else $error("scl low too short");
  property p_dev_hold_max;
    hold_q < 12'h76C;
  endproperty
  a_dev_hold_max: assert property (p_dev_hold_max) else $error("target held sda over nine bits");

  c_start: cover property ($fell(sda) && scl);
  c_ack: cover property ($rose(dev_sda_oe));
  c_stop: cover property ($rose(sda) && scl);
endmodule // pmbus_target_interface_props

//--- pmbus_target_interface_test.sv
`timescale 1ns/1ps
module pmbus_target_interface_test
  import pmbus_pkg::*;
;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [1:0]  adr_strap = 2'h0;
  logic [1:0]  strap2    = 2'h2;
  logic [7:0]  cur_cmd, rd_len, rd_idx, rd_byte, exec_cmd, rx_byte;
  logic [1:0]  cmd_len, exec_len;
  logic [15:0] exec_data;
  logic        exec_valid, pec_err, hung, hung2, busy, done, nacked, pec_bad, rx_valid;
  logic        go = 1'b0;
  op_t         go_op = op_send_byte;
  logic [6:0]  go_addr = 7'h00;
  logic [7:0]  go_cmd = 8'h00;
  logic [15:0] go_data = 16'h0000;
  logic        go_pec = 1'b0;
  int          error_cnt = 0, n_compared = 0, n_exec = 0, n_perr = 0, cyc = 0;
  logic [7:0]  rxq[$];
  op_t         wop[4] = '{op_send_byte, op_write_byte, op_write_word, op_write_word};
  op_t         rop[4] = '{op_read_byte, op_read_word, op_block_read, op_recv_byte};
  logic [7:0]  wcmd[4] = '{8'h00, 8'h01, 8'h02, 8'h02};
  logic [7:0]  rcmd[4] = '{8'h01, 8'h02, 8'h03, 8'h00};
  logic [7:0]  rn[4] = '{8'h01, 8'h02, 8'h04, 8'h01};
  logic [3:0]  wpec = 4'hA;
  logic [3:0]  rpec = 4'h5;

  pmbus_if b1 ();
  pmbus_if b2 ();

  always #25 mclk = ~mclk;

  // command low bits give the lengths; 3 is a block read
  assign cmd_len = (cur_cmd[1:0] == 2'h3) ? 2'h0 : cur_cmd[1:0];
  assign rd_len  = (cur_cmd[1:0] == 2'h3) ? 8'h04 : {6'h00, cur_cmd[1:0]};
  assign rd_byte = 8'h03 + {rd_idx[5:0], 2'h0};

  pmbus_target #(.MODEL2(1'b0)) pmbus_target_inst (.mclk(mclk), .nrst(nrst), .bus(b1.dev), .adr_strap(adr_strap),
    .cur_cmd(cur_cmd), .cmd_len(cmd_len), .rd_len(rd_len), .rd_idx(rd_idx), .rd_byte(rd_byte),
    .exec_valid(exec_valid), .exec_cmd(exec_cmd), .exec_len(exec_len), .exec_data(exec_data),
    .pec_err(pec_err), .hung(hung));
  pmbus_target #(.MODEL2(1'b1)) pmbus_target_inst2 (.mclk(mclk), .nrst(nrst), .bus(b2.dev), .adr_strap(strap2),
    .cur_cmd(), .cmd_len(2'h0), .rd_len(8'h00), .rd_idx(), .rd_byte(rd_byte), .exec_valid(), .exec_cmd(),
    .exec_len(), .exec_data(), .pec_err(), .hung(hung2));
  pmbus_host pmbus_host_inst (.mclk(mclk), .nrst(nrst), .bus(b1.host), .go(go), .go_op(go_op),
    .go_addr(go_addr), .go_cmd(go_cmd), .go_data(go_data), .go_pec(go_pec), .busy(busy), .done(done),
    .nacked(nacked), .pec_bad(pec_bad), .rx_valid(rx_valid), .rx_byte(rx_byte));
  pmbus_target_interface_props props_inst (.mclk(mclk), .nrst(nrst), .scl(b1.scl), .sda(b1.sda),
    .host_scl_o(b1.host_scl_o), .host_scl_oe(b1.host_scl_oe), .host_sda_o(b1.host_sda_o),
    .host_sda_oe(b1.host_sda_oe), .dev_sda_o(b1.dev_sda_o), .dev_sda_oe(b1.dev_sda_oe));

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int k = 0; k < 8; k++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  task automatic rst(input logic [1:0] s);
    nrst <= 1'b0;
    adr_strap <= s;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask

  task automatic run(input op_t op, input logic [6:0] a, input logic [7:0] c, input logic [15:0] d, input logic p);
    int k;
    k = 0;
    go <= 1'b1;
    go_op <= op;
    go_addr <= a;
    go_cmd <= c;
    go_data <= d;
    go_pec <= p;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    while (done !== 1'b1 && k < 30000) begin
      @(posedge mclk);
      k++;
    end
    if (k == 30000) chk(16'h0001, 16'h0000);
    repeat (4) @(posedge mclk);
  endtask

  // bench-driven host on the second bus, one quarter of a bit per call
  task automatic q(input logic c, input logic d);
    b2.host_scl_oe <= ~c;
    b2.host_sda_oe <= ~d;
    repeat (QTR_CYC) @(posedge mclk);
  endtask

  task automatic st();
    q(1'b1, 1'b1);
    q(1'b1, 1'b0);
    q(1'b0, 1'b0);
  endtask

  task automatic sp();
    q(1'b0, 1'b0);
    q(1'b1, 1'b0);
    q(1'b1, 1'b1);
  endtask

  task automatic wbyte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      q(1'b0, v[i]);
      q(1'b1, v[i]);
      q(1'b1, v[i]);
      q(1'b0, v[i]);
    end
    q(1'b0, 1'b1);
    q(1'b1, 1'b1);
    ack = (b2.sda === 1'b0);
    q(1'b1, 1'b1);
    q(1'b0, 1'b1);
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (exec_valid === 1'b1) n_exec++;
    if (pec_err === 1'b1) n_perr++;
    if (rx_valid === 1'b1) rxq.push_back(rx_byte);
    if (cyc == 110000) begin
      error_cnt++;
      $display("wrong value at %0t: run timed out", $time);
      stop_test();
    end
  end

  initial begin
    logic       ack;
    logic [7:0] p;
    logic [6:0] a1;
    b2.host_scl_o = 1'b0;
    b2.host_sda_o = 1'b0;
    b2.host_scl_oe = 1'b0;
    b2.host_sda_oe = 1'b0;
    a1 = {BASE_MODEL1, 2'h3};
    for (int i = 0; i < 4; i++) begin
      rst(2'(i));
      run(wop[i], {BASE_MODEL1, 2'(i)}, wcmd[i], 16'hC3A5, wpec[i]); // strap address
      chk(16'(n_exec), 16'(i + 1)); // executed
      chk({exec_len, exec_cmd}, {wcmd[i][1:0], wcmd[i]});
      chk(exec_data & (wcmd[i][1] ? 16'hFFFF : {8'h00, {8{wcmd[i][0]}}}),
          16'hC3A5 & (wcmd[i][1] ? 16'hFFFF : {8'h00, {8{wcmd[i][0]}}})); // data
      chk({15'h0000, nacked}, 16'(n_perr)); // acked, no error
    end
    $display("test strap_writes done");
    run(op_write_byte, {BASE_MODEL2, 2'h3}, 8'h01, 16'h0011, 1'b0);
    chk({nacked, 8'(n_exec)}, 9'h104); // other base refused
    run(op_recover, a1, 8'h00, 16'h0000, 1'b0);
    chk(hung, 1'b0);
    $display("test address done");
    p = crc_byte(crc_byte(crc_byte(8'h00, {a1, 1'b0}), 8'h01), 8'h3C);
    run(op_write_word, a1, 8'h01, {p ^ 8'h01, 8'h3C}, 1'b0);
    chk({8'(n_perr), 8'(n_exec)}, 16'h0104); // dropped
    run(op_write_word, a1, 8'h01, {p, 8'h3C}, 1'b0);
    chk({8'(n_perr), 8'(n_exec)}, 16'h0105); // good check executes
    chk({exec_len, exec_data[7:0]}, {2'h1, 8'h3C});
    $display("test pec_write done");
    for (int i = 0; i < 4; i++) begin
      rxq.delete();
      run(rop[i], a1, rcmd[i], 16'h0000, rpec[i]); // read kinds
      chk(16'(rxq.size()), {8'h00, rn[i]});
      for (int j = 0; j < int'(rn[i]); j++) chk(rxq[j], 8'h03 + 8'(4 * j));
      chk({pec_bad, nacked}, 2'h0); // read check byte
    end
    $display("test reads done");
    st();
    q(1'b1, 1'b0);
    q(1'b1, 1'b1);
    chk(hung2, 1'b1); // locked
    st();
    wbyte({BASE_MODEL2, 2'h2, 1'b0}, ack);
    sp();
    chk(ack, 1'b0); // own address refused
    repeat (16) begin
      q(1'b0, 1'b1);
      q(1'b1, 1'b1);
    end
    chk(hung2, 1'b0); // pulses free it
    st();
    wbyte({BASE_MODEL2, 2'h2, 1'b0}, ack);
    sp();
    chk(ack, 1'b1);
    st();
    q(1'b1, 1'b0);
    q(1'b1, 1'b1);
    chk(hung2, 1'b1);
    st();
    wbyte({BASE_MODEL1, 2'h0, 1'b0}, ack);
    sp();
    chk(hung2, 1'b0); // other address frees it
    $display("test lockup done");
    stop_test();
  end
endmodule // pmbus_target_interface_test
